/* File: hw/msd_decoder.sv */
// memory space decoder with snapshot low-byte capture
`timescale 1ns/10ps
module msd_decoder #(
    parameter int SNAP_N = 4
) (
    input wire logic clk,
    input wire logic resetn,
    // program fetch
    input wire logic pfetch_valid,
    input wire logic [msd_pkg::PADDR_W-1:0] pfetch_addr,
    output logic pf_flash_sel_q,
    output logic pf_vector_q,
    output logic pf_ctrlbits_q,
    // external data access (external-move class only)
    input wire logic xmove_valid,
    input wire logic xmove_write,
    input wire logic [msd_pkg::XADDR_W-1:0] xmove_addr,
    input wire logic [msd_pkg::DATA_W-1:0] xmove_rdata_in,
    output logic [4:0] xsel_q,
    output logic xwrite_en_q,
    output logic [msd_pkg::DATA_W-1:0] xrdata_q,
    // internal data access
    input wire logic iacc_valid,
    input wire logic iacc_indirect,
    input wire logic [msd_pkg::IADDR_W-1:0] iacc_addr,
    output logic [3:0] isel_q,
    output logic [msd_pkg::BANK_SEL_W-1:0] ibank_q,
    output logic [msd_pkg::REG_SEL_W-1:0] ireg_q,
    output logic ibitaddr_ok_q,
    // snapshot registers: high/low byte read strobes and live values
    input wire logic [SNAP_N-1:0] snap_hi_rd,
    input wire logic [SNAP_N-1:0] snap_lo_rd,
    input wire logic [SNAP_N*16-1:0] snap_live,
    output logic [msd_pkg::DATA_W-1:0] snap_rdata_q
);

    function automatic msd_pkg::msd_xsel_t xdecode(
        input logic [15:0] a
    );
        if (a <= msd_pkg::EXTRAM_HI)
            xdecode = msd_pkg::XSEL_RAM;
        else if (a >= msd_pkg::MULDIV_LO && a <= msd_pkg::MULDIV_HI)
            xdecode = msd_pkg::XSEL_MULDIV;
        else if (a >= msd_pkg::CONV_LO && a <= msd_pkg::CONV_HI)
            xdecode = msd_pkg::XSEL_CONV;
        else if (a >= msd_pkg::XCTL_LO && a <= msd_pkg::XCTL_HI)
            xdecode = msd_pkg::XSEL_CTRL;
        else
            xdecode = msd_pkg::XSEL_NONE;
    endfunction : xdecode

    function automatic msd_pkg::msd_isel_t idecode(
        input logic [7:0] a,
        input logic indirect
    );
        if (a <= msd_pkg::BANK_HI)
            idecode = msd_pkg::ISEL_BANK;
        else if (a <= msd_pkg::INTRAM_HI)
            idecode = msd_pkg::ISEL_RAM;
        else if (indirect)
            idecode = msd_pkg::ISEL_UPRAM;
        else
            idecode = msd_pkg::ISEL_SPECREG;
    endfunction : idecode

    logic [15:0] paddr_ext;
    msd_pkg::msd_xsel_t xsel_d;
    msd_pkg::msd_isel_t isel_d;
    // one captured low byte per snapshot register
    logic [msd_pkg::DATA_W-1:0] snap_lo_q [SNAP_N];

    assign paddr_ext = {1'b0, pfetch_addr};
    assign xsel_d = xdecode(xmove_addr);
    assign isel_d = idecode(iacc_addr, iacc_indirect);

    // program space: the whole 15-bit range lands in flash
    always_ff @(posedge clk) begin
        if (!resetn) begin
            pf_flash_sel_q <= 1'b0;
            pf_vector_q <= 1'b0;
            pf_ctrlbits_q <= 1'b0;
        end else begin
            pf_flash_sel_q <= pfetch_valid
                && paddr_ext <= msd_pkg::PROG_HI;
            pf_vector_q <= pfetch_valid
                && paddr_ext <= msd_pkg::VEC_HI;
            pf_ctrlbits_q <= pfetch_valid
                && paddr_ext >= msd_pkg::CTRLBITS_LO;
        end
    end

    // external space is only driven by the external-move strobe
    always_ff @(posedge clk) begin
        if (!resetn) begin
            xsel_q <= msd_pkg::XSEL_NONE;
            xwrite_en_q <= 1'b0;
            xrdata_q <= '0;
        end else begin
            xsel_q <= xmove_valid ? xsel_d : msd_pkg::XSEL_NONE;
            // unmapped writes are dropped, unmapped reads return zero
            xwrite_en_q <= xmove_valid && xmove_write
                && xsel_d != msd_pkg::XSEL_NONE;
            xrdata_q <= (xmove_valid && !xmove_write
                && xsel_d != msd_pkg::XSEL_NONE)
                ? xmove_rdata_in : '0;
        end
    end

    // internal space decode, 8-bit address covers all 256 locations
    always_ff @(posedge clk) begin
        if (!resetn) begin
            isel_q <= '0;
            ibank_q <= '0;
            ireg_q <= '0;
            ibitaddr_ok_q <= 1'b0;
        end else begin
            isel_q <= iacc_valid ? isel_d : 4'h0;
            ibank_q <= iacc_addr[4:3];
            ireg_q <= iacc_addr[2:0];
            ibitaddr_ok_q <= iacc_valid && iacc_addr >= msd_pkg::INTRAM_LO
                && iacc_addr <= msd_pkg::BITADR_HI;
        end
    end

    // low byte is frozen on the high read so the pair stays coherent
    // even while the live counter keeps moving between the two reads
    for (genvar g = 0; g < SNAP_N; g++) begin : g_snap
        always_ff @(posedge clk) begin
            if (!resetn)
                snap_lo_q[g] <= '0;
            else if (snap_hi_rd[g])
                snap_lo_q[g] <= snap_live[g*16 +: 8];
        end
    end

    // a low read presumes the high read came first
    always_ff @(posedge clk) begin
        if (!resetn) begin
            snap_rdata_q <= '0;
        end else begin
            snap_rdata_q <= '0;
            for (int i = 0; i < SNAP_N; i++) begin
                if (snap_hi_rd[i])
                    snap_rdata_q <= snap_live[i*16+8 +: 8];
                else if (snap_lo_rd[i])
                    snap_rdata_q <= snap_lo_q[i];
            end
        end
    end

    ram_sel_a: assert property (@(posedge clk)
        disable iff (!resetn)
        xmove_valid && xmove_addr <= msd_pkg::EXTRAM_HI
        |=> xsel_q == msd_pkg::XSEL_RAM)
        else $error("external ram not selected");
    muldiv_sel_a: assert property (@(posedge clk)
        disable iff (!resetn)
        xmove_valid && xmove_addr >= msd_pkg::MULDIV_LO
        && xmove_addr <= msd_pkg::MULDIV_HI
        |=> xsel_q == msd_pkg::XSEL_MULDIV)
        else $error("mul div space not selected");
    conv_sel_a: assert property (@(posedge clk)
        disable iff (!resetn)
        xmove_valid && xmove_addr >= msd_pkg::CONV_LO
        && xmove_addr <= msd_pkg::CONV_HI
        |=> xsel_q == msd_pkg::XSEL_CONV)
        else $error("converter area not selected");
    ctrl_sel_a: assert property (@(posedge clk)
        disable iff (!resetn)
        xmove_valid && xmove_addr >= msd_pkg::XCTL_LO
        && xmove_addr <= msd_pkg::XCTL_HI
        |=> xsel_q == msd_pkg::XSEL_CTRL)
        else $error("control space not selected");
    unmapped_zero_a: assert property (@(posedge clk)
        disable iff (!resetn)
        xsel_q == msd_pkg::XSEL_NONE |-> xrdata_q == '0 && !xwrite_en_q)
        else $error("unmapped access had an effect");
    no_xmove_a: assert property (@(posedge clk)
        disable iff (!resetn)
        !xmove_valid |=> xsel_q == msd_pkg::XSEL_NONE)
        else $error("external space hit without external move");
    upper_ind_a: assert property (@(posedge clk)
        disable iff (!resetn)
        iacc_valid && iacc_addr[7] && iacc_indirect
        |=> isel_q == msd_pkg::ISEL_UPRAM)
        else $error("indirect upper access missed ram");
    upper_dir_a: assert property (@(posedge clk)
        disable iff (!resetn)
        iacc_valid && iacc_addr[7] && !iacc_indirect
        |=> isel_q == msd_pkg::ISEL_SPECREG)
        else $error("direct upper access missed special register");
    bank_sel_a: assert property (@(posedge clk)
        disable iff (!resetn)
        iacc_valid && iacc_addr <= msd_pkg::BANK_HI
        |=> isel_q == msd_pkg::ISEL_BANK
        && ibank_q == $past(iacc_addr[4:3]))
        else $error("register bank decode wrong");
    vec_area_a: assert property (@(posedge clk)
        disable iff (!resetn)
        pfetch_valid |=> pf_flash_sel_q
        && pf_vector_q == ($past(paddr_ext) <= msd_pkg::VEC_HI))
        else $error("vector area flag wrong");
    ctrl_bits_a: assert property (@(posedge clk)
        disable iff (!resetn)
        pfetch_valid |=> pf_ctrlbits_q
        == ($past(paddr_ext) >= msd_pkg::CTRLBITS_LO))
        else $error("control bits flag wrong");
    idle_isel_a: assert property (@(posedge clk)
        disable iff (!resetn)
        !iacc_valid |=> isel_q == '0)
        else $error("internal select active while idle");
    bit_area_a: assert property (@(posedge clk)
        disable iff (!resetn)
        iacc_valid && iacc_addr >= msd_pkg::INTRAM_LO
        && iacc_addr <= msd_pkg::BITADR_HI |=> ibitaddr_ok_q)
        else $error("bit addressable area missed");
    snap_idle_a: assert property (@(posedge clk)
        disable iff (!resetn)
        snap_hi_rd == '0 && snap_lo_rd == '0 |=> snap_rdata_q == '0)
        else $error("snapshot data without a read");
    snap_pair_a: assert property (@(posedge clk)
        disable iff (!resetn)
        snap_hi_rd[0] ##1 (!snap_hi_rd[0] && snap_lo_rd[0])
        |=> snap_rdata_q == $past(snap_live[7:0], 2))
        else $error("snapshot low byte not captured");
endmodule : msd_decoder

/* File: hw/msd_pkg.sv */
// memory space decoder constants and select encodings
package msd_pkg;
    localparam int PADDR_W = 15;
    localparam int XADDR_W = 16;
    localparam int IADDR_W = 8;
    localparam int DATA_W = 8;
    // program space
    localparam logic [15:0] PROG_LO = 16'h0000;
    localparam logic [15:0] PROG_HI = 16'h7FFF;
    localparam logic [15:0] VEC_LO = 16'h0000;
    localparam logic [15:0] VEC_HI = 16'h00FF;
    localparam logic [15:0] CTRLBITS_LO = 16'h7F00;
    localparam logic [15:0] CTRLBITS_HI = 16'h7FFF;
    // external data space
    localparam logic [15:0] EXTRAM_LO = 16'h0000;
    localparam logic [15:0] EXTRAM_HI = 16'h0EF7;
    localparam logic [15:0] MULDIV_LO = 16'h0EF8;
    localparam logic [15:0] MULDIV_HI = 16'h0FD7;
    localparam logic [15:0] CONV_LO = 16'h0FD8;
    localparam logic [15:0] CONV_HI = 16'h0FFF;
    localparam logic [15:0] XCTL_LO = 16'h4020;
    localparam logic [15:0] XCTL_HI = 16'h40FF;
    // internal data space
    localparam logic [7:0] BANK_HI = 8'h1F;
    localparam logic [7:0] INTRAM_LO = 8'h20;
    localparam logic [7:0] INTRAM_HI = 8'h7F;
    localparam logic [7:0] BITADR_HI = 8'h2F;
    localparam logic [7:0] UPPER_LO = 8'h80;
    localparam int BANK_REGS = 8;
    localparam int BANK_SEL_W = 2;
    localparam int REG_SEL_W = 3;

    // external data select, one-hot
    typedef enum logic [4:0] {
        XSEL_NONE = 5'h01,
        XSEL_RAM = 5'h02,
        XSEL_MULDIV = 5'h04,
        XSEL_CONV = 5'h08,
        XSEL_CTRL = 5'h10
    } msd_xsel_t;

    // internal data select, one-hot
    typedef enum logic [3:0] {
        ISEL_BANK = 4'h1,
        ISEL_RAM = 4'h2,
        ISEL_UPRAM = 4'h4,
        ISEL_SPECREG = 4'h8
    } msd_isel_t;
endpackage : msd_pkg

/* File: tb/msd_decoder_tb_top.sv */
// self-checking bench for the memory space decoder
`timescale 1ns/10ps
module msd_decoder_tb_top;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic pfetch_valid = 1'b0;
    logic [14:0] pfetch_addr = 15'h0000;
    logic xmove_valid = 1'b0;
    logic xmove_write = 1'b0;
    logic [15:0] xmove_addr = 16'h0000;
    logic [7:0] xmove_rdata_in;
    logic iacc_valid = 1'b0;
    logic iacc_indirect = 1'b0;
    logic [7:0] iacc_addr = 8'h00;
    logic [3:0] snap_hi_rd = 4'h0;
    logic [3:0] snap_lo_rd = 4'h0;
    logic [63:0] snap_live;
    logic pf_flash_sel_q, pf_vector_q, pf_ctrlbits_q, xwrite_en_q;
    logic [4:0] xsel_q;
    logic [7:0] xrdata_q, snap_rdata_q;
    logic [3:0] isel_q;
    logic [1:0] ibank_q;
    logic [2:0] ireg_q;
    logic ibitaddr_ok_q;
    int err_count = 0;
    int checks = 0;

    always #5 clk = ~clk;

    msd_decoder #(.SNAP_N(4)) dut (.clk(clk), .resetn(resetn),
        .pfetch_valid(pfetch_valid), .pfetch_addr(pfetch_addr),
        .pf_flash_sel_q(pf_flash_sel_q), .pf_vector_q(pf_vector_q),
        .pf_ctrlbits_q(pf_ctrlbits_q), .xmove_valid(xmove_valid),
        .xmove_write(xmove_write), .xmove_addr(xmove_addr),
        .xmove_rdata_in(xmove_rdata_in), .xsel_q(xsel_q),
        .xwrite_en_q(xwrite_en_q), .xrdata_q(xrdata_q),
        .iacc_valid(iacc_valid), .iacc_indirect(iacc_indirect),
        .iacc_addr(iacc_addr), .isel_q(isel_q), .ibank_q(ibank_q),
        .ireg_q(ireg_q), .ibitaddr_ok_q(ibitaddr_ok_q),
        .snap_hi_rd(snap_hi_rd), .snap_lo_rd(snap_lo_rd),
        .snap_live(snap_live), .snap_rdata_q(snap_rdata_q));

    msd_far_model far (.clk(clk), .xmove_addr(xmove_addr),
        .xmove_rdata_in(xmove_rdata_in), .snap_live(snap_live));

    task automatic give_verdict();
        $display("checks=%0d errors=%0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic pf(input logic [14:0] a);
        @(posedge clk);
        pfetch_addr <= a;
        pfetch_valid <= 1'b1;
        @(posedge clk);
        pfetch_valid <= 1'b0;
        #1;
        chk(pf_flash_sel_q, 16'h0001);
        chk(pf_vector_q, a <= 15'h00FF);
        chk(pf_ctrlbits_q, a >= 15'h7F00);
    endtask : pf

    task automatic xa(input logic [15:0] a, input logic wr,
                      input logic [4:0] s);
        @(posedge clk);
        xmove_addr <= a;
        xmove_write <= wr;
        xmove_valid <= 1'b1;
        @(posedge clk);
        xmove_valid <= 1'b0;
        #1;
        chk(xsel_q, s);
        chk(xwrite_en_q, wr && s != 5'h01);
        // unmapped or write cycles must read back zero
        chk(xrdata_q, (wr || s == 5'h01) ? 8'h00
            : a[7:0] ^ a[15:8] ^ 8'h5A);
    endtask : xa

    task automatic ia(input logic [7:0] a, input logic ind,
                      input logic [3:0] s);
        @(posedge clk);
        iacc_addr <= a;
        iacc_indirect <= ind;
        iacc_valid <= 1'b1;
        @(posedge clk);
        iacc_valid <= 1'b0;
        #1;
        chk(isel_q, s);
        chk({ibank_q, ireg_q}, a[4:0]);
        chk(ibitaddr_ok_q, a >= 8'h20 && a <= 8'h2F);
    endtask : ia

    task automatic snap(input int i, input bit twice);
        logic [15:0] v;
        @(posedge clk);
        snap_hi_rd[i] <= 1'b1;
        @(posedge clk);
        v = snap_live[16*i +: 16];
        if (twice) begin
            @(posedge clk);
            v = snap_live[16*i +: 16];
        end
        snap_hi_rd[i] <= 1'b0;
        snap_lo_rd[i] <= 1'b1;
        #1;
        chk(snap_rdata_q, v[15:8]);
        @(posedge clk);
        snap_lo_rd[i] <= 1'b0;
        #1;
        chk(snap_rdata_q, v[7:0]);
    endtask : snap

    initial begin
        #20000;
        err_count++;
        give_verdict();
    end

    initial begin
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        #1;
        chk(xsel_q, msd_pkg::XSEL_NONE);
        pf(15'h0000);
        pf(15'h00FF);
        pf(15'h0100);
        pf(15'h7EFF);
        pf(15'h7F00);
        pf(15'h7FFF);
        xa(16'h0000, 1'b0, msd_pkg::XSEL_RAM);
        xa(16'h0EF7, 1'b1, msd_pkg::XSEL_RAM);
        xa(16'h0EF8, 1'b0, msd_pkg::XSEL_MULDIV);
        xa(16'h0FD7, 1'b1, msd_pkg::XSEL_MULDIV);
        xa(16'h0FD8, 1'b0, msd_pkg::XSEL_CONV);
        xa(16'h0FFF, 1'b0, msd_pkg::XSEL_CONV);
        xa(16'h1000, 1'b0, msd_pkg::XSEL_NONE);
        xa(16'h401F, 1'b1, msd_pkg::XSEL_NONE);
        xa(16'h4020, 1'b1, msd_pkg::XSEL_CTRL);
        xa(16'h40FF, 1'b0, msd_pkg::XSEL_CTRL);
        xa(16'hFFFF, 1'b0, msd_pkg::XSEL_NONE);
        ia(8'h00, 1'b0, msd_pkg::ISEL_BANK);
        ia(8'h1F, 1'b1, msd_pkg::ISEL_BANK);
        ia(8'h20, 1'b0, msd_pkg::ISEL_RAM);
        ia(8'h2F, 1'b1, msd_pkg::ISEL_RAM);
        ia(8'h30, 1'b0, msd_pkg::ISEL_RAM);
        ia(8'h7F, 1'b1, msd_pkg::ISEL_RAM);
        ia(8'h80, 1'b1, msd_pkg::ISEL_UPRAM);
        ia(8'hFF, 1'b1, msd_pkg::ISEL_UPRAM);
        ia(8'h80, 1'b0, msd_pkg::ISEL_SPECREG);
        ia(8'hFF, 1'b0, msd_pkg::ISEL_SPECREG);
        snap(0, 1'b0);
        snap(3, 1'b0);
        snap(2, 1'b1);
        give_verdict();
    end
endmodule : msd_decoder_tb_top

/* File: tb/msd_far_model.sv */
// far-side model: region read data and live snapshot values
`timescale 1ns/10ps
module msd_far_model (
    input wire logic clk,
    input wire logic [15:0] xmove_addr,
    output logic [7:0] xmove_rdata_in,
    output logic [63:0] snap_live
);
    logic [15:0] tick_q = 16'h1234;
    // both bytes move every cycle, so a late or missed capture shows
    always @(posedge clk) begin
        tick_q <= tick_q + 16'h0101;
    end
    assign snap_live = {tick_q ^ 16'hC3C3, tick_q, ~tick_q, tick_q + 16'h0F0F};
    assign xmove_rdata_in = xmove_addr[7:0] ^ xmove_addr[15:8] ^ 8'h5A;
endmodule : msd_far_model
